/* testbench/nand_device_model.sv */
`timescale 1ns/1ns
`default_nettype none
module nand_device_model (
    input  wire logic        clock,
    input  wire logic        reset,
    input  wire logic        cle,
    input  wire logic        we_n,
    input  wire logic        re_n,
    input  wire logic [15:0] io_wire,
    input  wire logic [15:0] busy_len,
    output var  logic [15:0] drive,
    output var  logic        ready_busy_n
);
    logic        we_n_r;
    logic [1:0]  start_r;
    logic [15:0] busy_r;
    logic [15:0] last_r;
    // Opcodes that start an internal operation: reset, reads, programs, erase
    wire  logic  latch = cle && we_n && !we_n_r && io_wire[7:0] inside
        {8'hFF, 8'h30, 8'h31, 8'h3F, 8'h10, 8'h15, 8'hD0};

    // Busy starts three cycles (60 ns) after the strobe rise, inside the 100 ns window
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            we_n_r  <= 1'b1;
            start_r <= 2'h0;
            busy_r  <= 16'h0000;
            last_r  <= 16'h0000;
        end else begin
            we_n_r  <= we_n;
            start_r <= latch ? 2'h2 : start_r - 2'(start_r != 2'h0);
            if (start_r == 2'h1)
                busy_r <= busy_len;
            else if (busy_r != 16'h0000)
                busy_r <= busy_r - 16'h0001;
            if (!re_n)
                last_r <= 16'h5AC3;
        end
    end

    assign ready_busy_n = busy_r == 16'h0000;
    // Released bus shows the inverse of the last word, so a stale sample shows
    assign drive = re_n ? ~last_r : 16'h5AC3;
endmodule
`default_nettype wire

/* testbench/nand_host_chk.sv */
`timescale 1ns/1ns
`default_nettype none
`include "nand_host_cfg.svh"
module nand_host_chk #(
    parameter bit WIDE_IO = 1'b0
) (
    input wire logic        clock,
    input wire logic        reset,
    input wire logic        done,
    input wire logic        timeout_err,
    input wire logic        refused,
    input wire logic        nand_cle,
    input wire logic        nand_ale,
    input wire logic        write_strobe_n,
    input wire logic        read_strobe_n,
    input wire logic [15:0] nand_io_out,
    input wire logic        nand_io_oe_n
);
    localparam int DMAX = WIDE_IO ? `PAGE_WORDS_X16 : `PAGE_BYTES_X8;
    logic        we_n_r;
    logic        seen_r;
    logic [1:0]  aidx_r;
    logic [5:0]  page_r;
    logic [3:0]  conf_r [64];
    logic [11:0] dcnt_r;
    wire  logic  wfall = we_n_r && !write_strobe_n;
    wire  logic  cfall = wfall && nand_cle;
    wire  logic  confirm = cfall && nand_io_out[7:0] inside {8'h10, 8'h15};

    // Shadow counts of data words and confirms per page, like the device
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            we_n_r <= 1'b1;
            seen_r <= 1'b0;
            aidx_r <= 2'h0;
            page_r <= 6'h00;
            dcnt_r <= 12'h000;
            conf_r <= '{default: 4'h0};
        end else begin
            we_n_r <= write_strobe_n;
            seen_r <= seen_r || cfall;
            if (cfall)
                aidx_r <= 2'h0;
            else if (wfall && nand_ale && aidx_r != 2'h3)
                aidx_r <= aidx_r + 2'h1;
            if (wfall && nand_ale && aidx_r == 2'h2)
                page_r <= nand_io_out[5:0];
            if (cfall && nand_io_out[7:0] == 8'h80)
                dcnt_r <= 12'h000;
            else if (wfall && !nand_cle && !nand_ale)
                dcnt_r <= dcnt_r + 12'h001;
            if (cfall && nand_io_out[7:0] == 8'hD0)
                conf_r <= '{default: 4'h0};
            else if (confirm)
                conf_r[page_r] <= conf_r[page_r] + 4'h1;
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (reset);

    write_blackout_a: assert property (
        $rose(write_strobe_n) && (nand_cle || nand_ale)
        |=> (write_strobe_n && read_strobe_n)[*5])
        else $error("strobe inside the write to busy delay");
    upper_zero_a: assert property (
        (nand_cle || nand_ale) && !nand_io_oe_n |-> nand_io_out[15:8] == 8'h00)
        else $error("upper lines not zero in a latch cycle");
    refuse_quiet_a: assert property (
        refused |-> done && write_strobe_n && $past(write_strobe_n))
        else $error("refused request moved the strobe");
    data_limit_a: assert property (int'(dcnt_r) <= DMAX)
        else $error("page data count exceeded");
    partial_limit_a: assert property (confirm |-> conf_r[page_r] < 4'h8)
        else $error("too many partial programs on one page");
    reset_first_a: assert property (cfall && !seen_r |->
        nand_io_out[7:0] == 8'hFF)
        else $error("first command after power-up is not reset");

    refuse_c: cover property (refused);
    timeout_c: cover property (timeout_err);
    full_page_c: cover property (int'(dcnt_r) == DMAX);
endmodule
bind nand_host nand_host_chk #(.WIDE_IO(WIDE_IO)) chk (.clock, .reset,
    .done, .timeout_err, .refused, .nand_cle, .nand_ale, .write_strobe_n,
    .read_strobe_n, .nand_io_out, .nand_io_oe_n);
`default_nettype wire

/* testbench/test_nand_host.sv */
`timescale 1ns/1ns
`default_nettype none
module test_nand_host;
    logic        clock, reset, cmd_valid, cmd_ready, done, timeout_err;
    logic        refused, nand_cle, nand_ale, write_strobe_n, read_strobe_n;
    logic        nand_io_oe_n, ready_busy_n, nand_ce_n, enable;
    logic [2:0]  cmd_op;
    logic [3:0]  wait_class;
    logic [15:0] cmd_data, rd_data, nand_io_out, model_drive, busy_len;
    int          num_errors, comparisons;
    // Shared data lines: the host wins whenever its drive enable is low
    wire  logic [15:0] nand_io_in = nand_io_oe_n ? model_drive : nand_io_out;

    // Short busy limits keep the run brief; reset erase, power-up reset, cache program and program are 40 cycles
    nand_host #(.WIDE_IO(1'b0), .RESET_ERASE_CYC(16'h0028),
        .RESET_POWER_CYC(16'h0028), .CACHE_PROG_CYC(16'h0028),
        .PROGRAM_CYC(16'h0028)) dut (.clock, .reset, .enable,
        .cmd_valid, .cmd_op, .cmd_data, .wait_class, .cmd_ready, .done,
        .rd_data, .timeout_err, .refused, .nand_ce_n, .nand_cle,
        .nand_ale, .write_strobe_n, .read_strobe_n, .nand_io_out,
        .nand_io_oe_n, .nand_io_in, .ready_busy_n);
    nand_device_model model (.clock, .reset, .cle(nand_cle),
        .we_n(write_strobe_n), .re_n(read_strobe_n), .io_wire(nand_io_in),
        .busy_len, .drive(model_drive), .ready_busy_n);

    always #10 clock = ~clock;

    task automatic chk(input logic ok, input string msg);
        comparisons++;
        if (ok !== 1'b1) begin
            num_errors++;
            $display("Error at %0t: %s", $time, msg);
        end
    endtask

    task automatic wrap_up();
        $display("Counts: %0d errors, %0d checks", num_errors, comparisons);
        if (num_errors == 0 && comparisons > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // One request; lat 0 skips the latency check
    task automatic op(input logic [2:0] o, input logic [15:0] d,
                      input logic [3:0] c, input logic xr, input logic xt,
                      input int lat);
        int n;
        n = 0;
        while (cmd_ready !== 1'b1) begin
            @(negedge clock);
            n++;
            if (n > 500) begin
                chk(1'b0, "command port never ready");
                wrap_up();
            end
        end
        @(posedge clock);
        cmd_op <= o;
        cmd_data <= d;
        wait_class <= c;
        cmd_valid <= 1'b1;
        @(posedge clock);
        cmd_valid <= 1'b0;
        n = 0;
        do begin
            @(negedge clock);
            n++;
        end while (done !== 1'b1 && n < 300);
        if (n >= 300) begin
            chk(1'b0, "no done");
            wrap_up();
        end
        chk(refused === xr && timeout_err === xt, "done flags wrong");
        if (lat != 0)
            chk(n == lat, "done latency wrong");
    endtask

    // Upper byte set on purpose: the host must zero it on the pins
    task automatic cmd(input logic [7:0] b, input logic xr);
        op(nand_host_pkg::OP_CMD, {8'hFF, b}, 4'h0, xr, 1'b0, xr ? 1 : 9);
    endtask
    task automatic prog_setup(input logic [7:0] page);
        cmd(8'h80, 1'b0);
        repeat (2) op(nand_host_pkg::OP_ADDR, 16'hFF00, 4'h0, 0, 0, 9);
        op(nand_host_pkg::OP_ADDR, {8'hFF, page}, 4'h0, 0, 0, 9);
    endtask
    task automatic wt(input logic [3:0] c, input logic xt);
        op(nand_host_pkg::OP_WAIT, 16'h0000, c, 1'b0, xt, 0);
    endtask

    // Every busy class after a reset, then reads with data check
    task automatic t_classes();
        for (int i = 0; i < 12; i++) begin
            cmd(8'hFF, 1'b0);
            wt(4'(i), 1'b0);
        end
        prog_setup(8'h00);
        cmd(8'h30, 1'b0);
        wt(nand_host_pkg::WAIT_READ, 1'b0);
        op(nand_host_pkg::OP_READ, 16'h0000, 4'h0, 1'b0, 1'b0, 0);
        chk(rd_data === 16'h00C3, "read data");
        cmd(8'h31, 1'b0);
        wt(nand_host_pkg::WAIT_CACHE_FIRST, 1'b0);
        cmd(8'h3F, 1'b0);
        wt(nand_host_pkg::WAIT_CACHE_NEXT, 1'b0);
        $display("Test classes done");
    endtask

    // Program too slow for the watchdog, then a second wait sees ready
    task automatic t_slow();
        busy_len <= 16'h0046;
        prog_setup(8'h00);
        op(nand_host_pkg::OP_WRITE, 16'h00A5, 4'h0, 1'b0, 1'b0, 0);
        cmd(8'h10, 1'b0);
        wt(nand_host_pkg::WAIT_PROGRAM, 1'b1);
        wt(nand_host_pkg::WAIT_PROGRAM, 1'b0);
        busy_len <= 16'h0014;
        cmd(8'h15, 1'b0);
        wt(nand_host_pkg::WAIT_CACHE_PROG, 1'b0);
        $display("Test slow done");
    endtask

    // Ninth confirm on one page is refused until an erase
    task automatic t_partial();
        for (int i = 0; i < 9; i++) begin
            prog_setup(8'h05);
            cmd(8'h10, i == 8);
        end
        cmd(8'hD0, 1'b0);
        prog_setup(8'h05);
        cmd(8'h10, 1'b0);
        $display("Test partial done");
    endtask

    // A full page of data, then one word too many
    task automatic t_full();
        cmd(8'h80, 1'b0);
        for (int i = 0; i < 2112; i++)
            op(nand_host_pkg::OP_WRITE, 16'(i & 255), 4'h0, 0, 0, 0);
        op(nand_host_pkg::OP_WRITE, 16'h0000, 4'h0, 1, 0, 1);
        $display("Test full done");
    endtask

    // Frozen host ignores a standing request, then takes it on release
    task automatic t_freeze();
        int n;
        n = 0;
        @(posedge clock);
        enable <= 1'b0;
        cmd_op <= nand_host_pkg::OP_READ;
        cmd_data <= 16'h0000;
        cmd_valid <= 1'b1;
        repeat (4) @(negedge clock);
        chk(cmd_ready === 1'b1 && read_strobe_n === 1'b1 && done === 1'b0,
            "frozen host moved");
        @(posedge clock);
        enable <= 1'b1;
        @(posedge clock);
        cmd_valid <= 1'b0;
        do begin
            @(negedge clock);
            n++;
        end while (done !== 1'b1 && n < 20);
        chk(n == 5 && rd_data === 16'h00C3, "read after freeze wrong");
        $display("Test freeze done");
    endtask

    initial begin
        clock = 1'b0;
        reset = 1'b1;
        enable = 1'b1;
        cmd_valid = 1'b0;
        cmd_op = 3'h0;
        cmd_data = 16'h0000;
        wait_class = 4'h0;
        busy_len = 16'h0014;
        num_errors = 0;
        comparisons = 0;
        repeat (2) @(posedge clock);
        reset <= 1'b0;
        for (int n = 0; cmd_ready !== 1'b1; n++) begin
            @(negedge clock);
            if (n > 500) begin
                chk(1'b0, "power-up never ends");
                wrap_up();
            end
        end
        chk(ready_busy_n === 1'b1 && done === 1'b0 && nand_ce_n === 1'b0,
            "power-up");
        t_classes();
        t_slow();
        t_partial();
        t_full();
        t_freeze();
        wrap_up();
    end
endmodule
`default_nettype wire

/* verilog/nand_host.sv */
// Operation
// - No new command is issued within 100 ns after the write strobe rises; the host keeps this gap only after command and address strobes.
// - At most eight partial programs hit one page between erasures.
// - On x16 parts upper I/O lines are zero in command and address cycles.
// - A page of data input is at most 2112 bytes or 1056 words.
// - After power-up a reset goes out first, with up to 1 ms of busy.
`include "nand_host_cfg.svh"
`timescale 1ns/1ns
`default_nettype none

module nand_host #(
    parameter bit         WIDE_IO        = 1'b0,
    parameter logic [15:0] RESET_ERASE_CYC = 16'(`US_MAX_CYC(`RESET_ERASE_US)),
    parameter logic [15:0] RESET_POWER_CYC = 16'(`US_MAX_CYC(`RESET_POWER_US)),
    parameter logic [15:0] CACHE_PROG_CYC  =
        16'(`US_MAX_CYC(`CACHE_PROGRAM_BUSY_US)),
    parameter logic [15:0] PROGRAM_CYC     =
        16'(`US_MAX_CYC(`PAGE_PROGRAM_TIME_US))
) (
    input  wire logic        clock,
    input  wire logic        reset,
    input  wire logic        enable,
    input  wire logic        cmd_valid,
    input  wire logic [2:0]  cmd_op,
    input  wire logic [15:0] cmd_data,
    input  wire logic [3:0]  wait_class,
    output var  logic        cmd_ready,
    output var  logic        done,
    output var  logic [15:0] rd_data,
    output var  logic        timeout_err,
    output var  logic        refused,
    output var  logic        nand_ce_n,
    output var  logic        nand_cle,
    output var  logic        nand_ale,
    output var  logic        write_strobe_n,
    output var  logic        read_strobe_n,
    output var  logic [15:0] nand_io_out,
    output var  logic        nand_io_oe_n,
    input  wire logic [15:0] nand_io_in,
    input  wire logic        ready_busy_n
);

    // Twelve bits: a full x8 page of 2112 does not fit in eleven
    localparam logic [11:0] PAGE_LIMIT = WIDE_IO ?
        12'(`PAGE_WORDS_X16) : 12'(`PAGE_BYTES_X8);
    localparam logic [15:0] GAP_CYC = 16'(`WRITE_TO_BUSY_DELAY_CYC - 1);

    nand_host_pkg::state_type state_r;
    logic [15:0] cnt_r;
    logic [1:0]  init_r;          // 0 issue reset, 1 waiting, 2 done
    logic [3:0]  sel_r;
    logic [11:0] data_cnt_r;
    logic [1:0]  addr_idx_r;
    logic [5:0]  page_r;
    logic [3:0]  pp_cnt_r [64];
    logic        cmd_ready_r, done_r, timeout_r, refused_r;
    logic [15:0] rd_data_r, io_out_r;
    logic        ce_n_r, cle_r, ale_r, we_n_r, re_n_r, oe_n_r;

    // Busy watchdog limit for each wait class
    function automatic logic [15:0] wait_limit(input logic [3:0] sel);
        case (sel)
            nand_host_pkg::WAIT_READ:
                wait_limit = 16'(`US_MAX_CYC(`READ_BUSY_US));
            nand_host_pkg::WAIT_CACHE_FIRST:
                wait_limit = 16'(`US_MAX_CYC(`FIRST_CACHE_READ_BUSY_US));
            nand_host_pkg::WAIT_CACHE_NEXT:
                wait_limit = 16'(`US_MAX_CYC(`NEXT_CACHE_READ_BUSY_US));
            nand_host_pkg::WAIT_RST_READ:
                wait_limit = 16'(`US_MAX_CYC(`RESET_READ_US));
            nand_host_pkg::WAIT_RST_PROG:
                wait_limit = 16'(`US_MAX_CYC(`RESET_PROGRAM_US));
            nand_host_pkg::WAIT_RST_ERASE: wait_limit = RESET_ERASE_CYC;
            nand_host_pkg::WAIT_RST_POWER: wait_limit = RESET_POWER_CYC;
            nand_host_pkg::WAIT_RST_IDLE:
                wait_limit = 16'(`US_MAX_CYC(`RESET_IDLE_US));
            nand_host_pkg::WAIT_CACHE_PROG: wait_limit = CACHE_PROG_CYC;
            nand_host_pkg::WAIT_LOCKED:
                wait_limit = 16'(`US_MAX_CYC(`LOCKED_BLOCK_BUSY_US));
            nand_host_pkg::WAIT_OTP_PROT:
                wait_limit = 16'(`US_MAX_CYC(`PROTECTED_OTP_BUSY_US));
            default: wait_limit = PROGRAM_CYC;
        endcase
    endfunction

    // Request decode
    wire       accept   = (state_r == nand_host_pkg::ST_IDLE) && cmd_ready_r
                          && cmd_valid;
    wire       is_cmd   = cmd_op == nand_host_pkg::OP_CMD;
    wire       is_addr  = cmd_op == nand_host_pkg::OP_ADDR;
    wire       is_write = cmd_op == nand_host_pkg::OP_WRITE;
    wire       is_read  = cmd_op == nand_host_pkg::OP_READ;
    wire       is_conf  = is_cmd &&
                          (cmd_data[7:0] == `OPC_PROGRAM_CONFIRM ||
                           cmd_data[7:0] == `OPC_CACHE_PROG_CONFIRM);
    wire       over_pp  = is_conf &&
                          pp_cnt_r[page_r] >= 4'(`PARTIAL_PROGRAM_LIMIT);
    wire       over_dat = is_write && data_cnt_r >= PAGE_LIMIT;
    wire       refuse   = over_pp || over_dat;
    wire       start_wr = accept && !refuse && (is_cmd || is_addr || is_write);
    // Upper lane forced to zero outside data cycles
    wire [15:0] wr_word = (is_cmd || is_addr) ?
                          {8'h00, cmd_data[7:0]} : cmd_data;
    wire [15:0] io_in_m = WIDE_IO ? nand_io_in : {8'h00, nand_io_in[7:0]};
    wire        busy_over = cnt_r >= wait_limit(sel_r);

    // Sequencer and pin drivers
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            state_r     <= nand_host_pkg::ST_IDLE;
            cnt_r       <= 16'h0000;
            init_r      <= 2'h0;
            sel_r       <= 4'h0;
            cmd_ready_r <= 1'b0;
            done_r      <= 1'b0;
            timeout_r   <= 1'b0;
            refused_r   <= 1'b0;
            rd_data_r   <= 16'h0000;
            io_out_r    <= 16'h0000;
            ce_n_r      <= 1'b1;
            cle_r       <= 1'b0;
            ale_r       <= 1'b0;
            we_n_r      <= 1'b1;
            re_n_r      <= 1'b1;
            oe_n_r      <= 1'b1;
        end else if (enable) begin
            done_r    <= 1'b0;
            timeout_r <= 1'b0;
            refused_r <= 1'b0;
            case (state_r)
                nand_host_pkg::ST_IDLE: begin
                    if (init_r == 2'h0) begin
                        // Power-up reset goes out before any user op
                        init_r   <= 2'h1;
                        ce_n_r   <= 1'b0;
                        cle_r    <= 1'b1;
                        io_out_r <= {8'h00, `OPC_RESET};
                        oe_n_r   <= 1'b0;
                        we_n_r   <= 1'b0;
                        cnt_r    <= 16'h0001;
                        state_r  <= nand_host_pkg::ST_WLOW;
                    end else if (accept) begin
                        cmd_ready_r <= 1'b0;
                        if (refuse) begin
                            done_r      <= 1'b1;
                            refused_r   <= 1'b1;
                            cmd_ready_r <= 1'b1;
                        end else if (start_wr) begin
                            cle_r    <= is_cmd;
                            ale_r    <= is_addr;
                            io_out_r <= wr_word;
                            oe_n_r   <= 1'b0;
                            we_n_r   <= 1'b0;
                            cnt_r    <= 16'h0001;
                            state_r  <= nand_host_pkg::ST_WLOW;
                        end else if (is_read) begin
                            re_n_r  <= 1'b0;
                            cnt_r   <= 16'h0001;
                            state_r <= nand_host_pkg::ST_RLOW;
                        end else begin
                            sel_r   <= cmd_op == nand_host_pkg::OP_WAIT ?
                                       wait_class : sel_r;
                            cnt_r   <= 16'h0000;
                            state_r <= nand_host_pkg::ST_BUSY;
                        end
                    end
                end
                nand_host_pkg::ST_WLOW: begin
                    // Two low cycles give 40 ns of pulse and data setup
                    if (cnt_r == 16'h0000) begin
                        we_n_r  <= 1'b1;
                        state_r <= nand_host_pkg::ST_WHIGH;
                    end else begin
                        cnt_r <= cnt_r - 16'h0001;
                    end
                end
                nand_host_pkg::ST_WHIGH: begin
                    // One cycle of hold, then release lines
                    cle_r   <= 1'b0;
                    ale_r   <= 1'b0;
                    oe_n_r  <= 1'b1;
                    cnt_r   <= (cle_r || ale_r) ? GAP_CYC : 16'h0000;
                    state_r <= nand_host_pkg::ST_GAP;
                end
                nand_host_pkg::ST_GAP: begin
                    // Ready/busy is not trusted inside this window
                    if (cnt_r == 16'h0000) begin
                        if (init_r == 2'h1) begin
                            sel_r   <= nand_host_pkg::WAIT_RST_POWER;
                            state_r <= nand_host_pkg::ST_BUSY;
                        end else begin
                            done_r      <= 1'b1;
                            cmd_ready_r <= 1'b1;
                            state_r     <= nand_host_pkg::ST_IDLE;
                        end
                    end else begin
                        cnt_r <= cnt_r - 16'h0001;
                    end
                end
                nand_host_pkg::ST_RLOW: begin
                    // Sample at 40 ns, past the 30 ns access time
                    if (cnt_r == 16'h0000) begin
                        rd_data_r <= io_in_m;
                        re_n_r    <= 1'b1;
                        cnt_r     <= 16'h0001;
                        state_r   <= nand_host_pkg::ST_RHIGH;
                    end else begin
                        cnt_r <= cnt_r - 16'h0001;
                    end
                end
                nand_host_pkg::ST_RHIGH: begin
                    if (cnt_r == 16'h0000) begin
                        done_r      <= 1'b1;
                        cmd_ready_r <= 1'b1;
                        state_r     <= nand_host_pkg::ST_IDLE;
                    end else begin
                        cnt_r <= cnt_r - 16'h0001;
                    end
                end
                nand_host_pkg::ST_BUSY: begin
                    // Wait for ready, bounded by the class watchdog
                    if (ready_busy_n || busy_over) begin
                        timeout_r   <= !ready_busy_n;
                        done_r      <= init_r == 2'h2;
                        init_r      <= 2'h2;
                        cmd_ready_r <= 1'b1;
                        state_r     <= nand_host_pkg::ST_IDLE;
                    end else begin
                        cnt_r <= cnt_r + 16'h0001;
                    end
                end
                default: state_r <= nand_host_pkg::ST_IDLE;
            endcase
        end
    end

    // Page tracking: data count, row capture, partial program counts
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            data_cnt_r <= 12'h000;
            addr_idx_r <= 2'h0;
            page_r     <= 6'h00;
            for (int i = 0; i < 64; i++) pp_cnt_r[i] <= 4'h0;
        end else if (enable && start_wr) begin
            if (is_cmd) begin
                addr_idx_r <= 2'h0;
                if (cmd_data[7:0] == `OPC_PROGRAM_SETUP)
                    data_cnt_r <= 12'h000;
                if (is_conf)
                    pp_cnt_r[page_r] <= pp_cnt_r[page_r] + 4'h1;
                if (cmd_data[7:0] == `OPC_ERASE_CONFIRM)
                    for (int i = 0; i < 64; i++) pp_cnt_r[i] <= 4'h0;
            end else if (is_addr) begin
                if (addr_idx_r != 2'h3)
                    addr_idx_r <= addr_idx_r + 2'h1;
                if (addr_idx_r == 2'(`ROW_ADDR_INDEX))
                    page_r <= cmd_data[5:0];
            end else begin
                data_cnt_r <= data_cnt_r + 12'h001;
            end
        end
    end

    assign cmd_ready      = cmd_ready_r;
    assign done           = done_r;
    assign rd_data        = rd_data_r;
    assign timeout_err    = timeout_r;
    assign refused        = refused_r;
    assign nand_ce_n      = ce_n_r;
    assign nand_cle       = cle_r;
    assign nand_ale       = ale_r;
    assign write_strobe_n = we_n_r;
    assign read_strobe_n  = re_n_r;
    assign nand_io_out    = io_out_r;
    assign nand_io_oe_n   = oe_n_r;

endmodule

`default_nettype wire

/* verilog/nand_host_cfg.svh */
`ifndef NAND_HOST_CFG_SVH
`define NAND_HOST_CFG_SVH

// Clock and conversion of times to cycles
`define CLK_PERIOD_NS 20
`define NS_MIN_CYC(ns) (((ns) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define US_MAX_CYC(us) (((us) * 1000) / `CLK_PERIOD_NS)

// Blackout after a write strobe rise, in ns
`define WRITE_TO_BUSY_DELAY_NS 100
`define WRITE_TO_BUSY_DELAY_CYC `NS_MIN_CYC(`WRITE_TO_BUSY_DELAY_NS)

// Busy limits in microseconds
`define READ_BUSY_US            25
`define FIRST_CACHE_READ_BUSY_US 3
`define NEXT_CACHE_READ_BUSY_US 25
`define RESET_READ_US           5
`define RESET_PROGRAM_US        10
`define RESET_ERASE_US          500
`define RESET_POWER_US          1000
`define RESET_IDLE_US           5
`define CACHE_PROGRAM_BUSY_US   700
`define LOCKED_BLOCK_BUSY_US    3
`define PROTECTED_OTP_BUSY_US   30
`define PAGE_PROGRAM_TIME_US    700

// Page geometry and program limits
`define PARTIAL_PROGRAM_LIMIT   8
`define PAGE_BYTES_X8           2112
`define PAGE_WORDS_X16          1056
`define ROW_ADDR_INDEX          2

// Opcodes the host tracks
`define OPC_RESET               8'hFF
`define OPC_PROGRAM_SETUP       8'h80
`define OPC_PROGRAM_CONFIRM     8'h10
`define OPC_CACHE_PROG_CONFIRM  8'h15
`define OPC_ERASE_CONFIRM       8'hD0

`endif

/* verilog/nand_host_pkg.sv */
package nand_host_pkg;

    typedef enum logic [2:0] {
        OP_CMD   = 3'h0,
        OP_ADDR  = 3'h1,
        OP_WRITE = 3'h2,
        OP_READ  = 3'h3,
        OP_WAIT  = 3'h4
    } op_type;

    typedef enum logic [3:0] {
        WAIT_READ        = 4'h0,
        WAIT_CACHE_FIRST = 4'h1,
        WAIT_CACHE_NEXT  = 4'h2,
        WAIT_RST_READ    = 4'h3,
        WAIT_RST_PROG    = 4'h4,
        WAIT_RST_ERASE   = 4'h5,
        WAIT_RST_POWER   = 4'h6,
        WAIT_RST_IDLE    = 4'h7,
        WAIT_CACHE_PROG  = 4'h8,
        WAIT_LOCKED      = 4'h9,
        WAIT_OTP_PROT    = 4'hA,
        WAIT_PROGRAM     = 4'hB
    } wait_class_type;

    typedef enum logic [6:0] {
        ST_IDLE  = 7'h01,
        ST_WLOW  = 7'h02,
        ST_WHIGH = 7'h04,
        ST_GAP   = 7'h08,
        ST_RLOW  = 7'h10,
        ST_RHIGH = 7'h20,
        ST_BUSY  = 7'h40
    } state_type;

endpackage
